//--- verilog/bcsb_pkg.sv
`default_nettype none
package bcsb_pkg;
    // Register indices. The status index is not word-aligned, so the command and status registers each get their own aligned
    // word at four times their index, and each 16-bit word sits in the low half of that word.
    localparam logic [11:0] CMD_ADDR = 12'h004;
    localparam logic [11:0] STS_ADDR = 12'h006;
    localparam logic [11:0] CMD_BYTE_ADDR = {CMD_ADDR[9:0], 2'b00};
    localparam logic [11:0] STS_BYTE_ADDR = {STS_ADDR[9:0], 2'b00};
    localparam logic [11:0] ERRCTL_BYTE_ADDR = 12'h020;
    localparam logic [11:0] PORT_BYTE_ADDR = 12'h024;
    localparam int ADDR_W = 12;

    // Command word fields.
    localparam int CMD_POISON_EN_BIT = 6;
    localparam int CMD_ADDR_STEP_BIT = 7;
    localparam int CMD_ERR_EN_BIT = 8;
    localparam int CMD_FAST_B2B_BIT = 9;
    localparam int CMD_IRQ_DIS_BIT = 10;
    localparam logic [15:0] CMD_WRITE_MASK = 16'h0540;
    localparam logic [15:0] CMD_RESET = 16'h0000;

    // Status word fields.
    localparam int STS_IRQ_PEND_BIT = 3;
    localparam int STS_CAP_LIST_BIT = 4;
    localparam int STS_HS_CAP_BIT = 5;
    localparam int STS_FAST_B2B_BIT = 7;
    localparam int STS_POISON_BIT = 8;
    localparam logic [15:0] STS_RESET = 16'h0010;

    // Express device control: bit 0 non-fatal enable, bit 1 fatal enable.
    localparam int DCTL_NONFATAL_BIT = 0;
    localparam int DCTL_FATAL_BIT = 1;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic poisoned_cpl;
        logic poisoned_wr;
        logic primary_side;
    } bcsb_traffic_s;

    typedef struct packed {
        logic fatal;
        logic nonfatal;
    } bcsb_err_s;
endpackage : bcsb_pkg
`default_nettype wire

//--- verilog/bcsb_regs.sv
// Notes on behaviour
// - Enabled poison reporting sets master poison flag.
// - Reporting disabled never sets master poison flag.
// - Report errors if command or device-control enabled.
// - Command bit 10 gates legacy interrupt messages.
// - Downstream port hot-plug interrupt shows pending.
// - Forwarded emulated interrupts never show pending.
// - Upstream port always reads pending as zero.
// - Capability list bit reads constant one.
// - Poison flag resets zero, write-one clears.
// - Stepping, fast, speed, reserved bits read zero.
`timescale 1ns/1ps
`default_nettype none
module bcsb_regs #(
    parameter bit UPSTREAM_PORT = 1'b0 // Set for the upstream port instance.
) (
    input wire logic aclk, // 10 MHz clock.
    input wire logic aresetn, // Synchronous reset, active low.
    input wire logic [11:0] s_axi_awaddr, // Write address.
    input wire logic s_axi_awvalid, // Write address valid.
    output logic s_axi_awready, // Write address ready.
    input wire logic [31:0] s_axi_wdata, // Write data.
    input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
    input wire logic s_axi_wvalid, // Write data valid.
    output logic s_axi_wready, // Write data ready.
    output logic [1:0] s_axi_bresp, // Write response.
    output logic s_axi_bvalid, // Write response valid.
    input wire logic s_axi_bready, // Write response ready.
    input wire logic [11:0] s_axi_araddr, // Read address.
    input wire logic s_axi_arvalid, // Read address valid.
    output logic s_axi_arready, // Read address ready.
    output logic [31:0] s_axi_rdata, // Read data.
    output logic [1:0] s_axi_rresp, // Read response.
    output logic s_axi_rvalid, // Read data valid.
    input wire logic s_axi_rready, // Read data ready.
    input wire bcsb_pkg::bcsb_traffic_s traffic, // Received poisoned traffic strobe.
    input wire bcsb_pkg::bcsb_err_s err_detect, // Detected error strobes.
    input wire logic hotplug_irq, // Hot-plug controller interrupt level.
    input wire logic forwarded_irq, // Emulated interrupt forwarded from below.
    output logic legacy_irq_assert, // Legacy interrupt message may be sent.
    output bcsb_pkg::bcsb_err_s err_report, // Error report toward root complex.
    output logic poison_report_enable, // Command bit 6.
    output logic error_report_enable // Command bit 8.
);
    logic [15:0] cmd_q, cmd_d;
    logic poison_q, poison_d;
    logic [1:0] dctl_q, dctl_d;
    logic irq_pend_q, irq_pend_d;
    logic aw_q, aw_d;
    logic w_q, w_d;
    logic b_q, b_d;
    logic r_q, r_d;
    logic [11:0] awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    bcsb_pkg::bcsb_err_s rep_q, rep_d;
    logic wr_fire;
    logic poison_event;
    logic clr_poison;

    function automatic logic mapped(input logic [11:0] a);
        mapped = (a == bcsb_pkg::CMD_BYTE_ADDR) || (a == bcsb_pkg::STS_BYTE_ADDR)
            || (a == bcsb_pkg::ERRCTL_BYTE_ADDR) || (a == bcsb_pkg::PORT_BYTE_ADDR);
    endfunction : mapped

    function automatic logic [15:0] status_word(input logic pend, input logic poison);
        status_word = 16'h0000;
        status_word[bcsb_pkg::STS_IRQ_PEND_BIT] = pend;
        status_word[bcsb_pkg::STS_CAP_LIST_BIT] = 1'b1;
        status_word[bcsb_pkg::STS_POISON_BIT] = poison;
    endfunction : status_word

    assign s_axi_awready = !aw_q && !b_q;
    assign s_axi_wready = !w_q && !b_q;
    assign s_axi_arready = !r_q;
    assign s_axi_bvalid = b_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = r_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign wr_fire = aw_q && w_q && !b_q;
    assign poison_report_enable = cmd_q[bcsb_pkg::CMD_POISON_EN_BIT];
    assign error_report_enable = cmd_q[bcsb_pkg::CMD_ERR_EN_BIT];
    assign err_report = rep_q;
    // Only primary-side poisoned traffic counts, and only while reporting is on.
    assign poison_event = poison_report_enable && traffic.primary_side
        && (traffic.poisoned_cpl || traffic.poisoned_wr);
    assign clr_poison = wr_fire && awaddr_q == bcsb_pkg::STS_BYTE_ADDR && wstrb_q[1]
        && wdata_q[bcsb_pkg::STS_POISON_BIT];
    // The interrupt stays held off by the disable bit, but pending still shows the cause.
    assign legacy_irq_assert = irq_pend_q && !cmd_q[bcsb_pkg::CMD_IRQ_DIS_BIT];

    always_comb
    begin
        aw_d = aw_q;
        w_d = w_q;
        b_d = b_q;
        awaddr_d = awaddr_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bresp_d = bresp_q;
        cmd_d = cmd_q;
        dctl_d = dctl_q;
        if (s_axi_awvalid && s_axi_awready)
        begin
            aw_d = 1'b1;
            awaddr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            w_d = 1'b1;
            wdata_d = s_axi_wdata;
            wstrb_d = s_axi_wstrb;
        end
        if (wr_fire)
        begin
            aw_d = 1'b0;
            w_d = 1'b0;
            b_d = 1'b1;
            bresp_d = mapped(awaddr_q) ? bcsb_pkg::RESP_OKAY : bcsb_pkg::RESP_SLVERR;
            if (awaddr_q == bcsb_pkg::CMD_BYTE_ADDR)
            begin
                if (wstrb_q[0])
                    cmd_d[7:0] = wdata_q[7:0] & bcsb_pkg::CMD_WRITE_MASK[7:0];
                if (wstrb_q[1])
                    cmd_d[15:8] = wdata_q[15:8] & bcsb_pkg::CMD_WRITE_MASK[15:8];
            end
            if (awaddr_q == bcsb_pkg::ERRCTL_BYTE_ADDR && wstrb_q[0])
                dctl_d = wdata_q[1:0];
        end
        else if (b_q && s_axi_bready)
            b_d = 1'b0;
    end

    always_comb
    begin
        // A new poison event in the clearing cycle wins over the clear.
        poison_d = poison_event ? 1'b1 : (clr_poison ? 1'b0 : poison_q);
        // Forwarded interrupts are ignored here; only the port's own hot-plug source counts.
        irq_pend_d = UPSTREAM_PORT ? 1'b0 : hotplug_irq;
        rep_d.fatal = err_detect.fatal
            && (cmd_q[bcsb_pkg::CMD_ERR_EN_BIT] || dctl_q[bcsb_pkg::DCTL_FATAL_BIT]);
        rep_d.nonfatal = err_detect.nonfatal
            && (cmd_q[bcsb_pkg::CMD_ERR_EN_BIT] || dctl_q[bcsb_pkg::DCTL_NONFATAL_BIT]);
    end

    always_comb
    begin
        r_d = r_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (s_axi_arvalid && s_axi_arready)
        begin
            r_d = 1'b1;
            rresp_d = mapped(s_axi_araddr) ? bcsb_pkg::RESP_OKAY : bcsb_pkg::RESP_SLVERR;
            case (s_axi_araddr)
                bcsb_pkg::CMD_BYTE_ADDR: rdata_d = {16'h0000, cmd_q};
                bcsb_pkg::STS_BYTE_ADDR: rdata_d = {16'h0000, status_word(irq_pend_q, poison_q)};
                bcsb_pkg::ERRCTL_BYTE_ADDR: rdata_d = {30'h0, dctl_q};
                bcsb_pkg::PORT_BYTE_ADDR: rdata_d = {31'h0, UPSTREAM_PORT};
                default: rdata_d = 32'h00000000;
            endcase
        end
        else if (r_q && s_axi_rready)
            r_d = 1'b0;
    end

    // Write path and the writable control bits.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            b_q <= 1'b0;
            awaddr_q <= 12'h000;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
            bresp_q <= 2'h0;
            cmd_q <= bcsb_pkg::CMD_RESET;
            dctl_q <= 2'h0;
        end
        else
        begin
            aw_q <= aw_d;
            w_q <= w_d;
            b_q <= b_d;
            awaddr_q <= awaddr_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            bresp_q <= bresp_d;
            cmd_q <= cmd_d;
            dctl_q <= dctl_d;
        end
    end

    // Status flags and the error report.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            poison_q <= 1'b0;
            irq_pend_q <= 1'b0;
            rep_q <= '0;
        end
        else
        begin
            poison_q <= poison_d;
            irq_pend_q <= irq_pend_d;
            rep_q <= rep_d;
        end
    end

    // Read path.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            r_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= 2'h0;
        end
        else
        begin
            r_q <= r_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
        end
    end

    a_poison_sets: assert property (@(posedge aclk) disable iff (!aresetn)
        poison_event |=> poison_q)
        else $error("Poison flag not set after enabled poisoned traffic.");
    a_poison_off: assert property (@(posedge aclk) disable iff (!aresetn)
        (!poison_q && !poison_report_enable) |=> !poison_q)
        else $error("Poison flag set while reporting disabled.");
    a_poison_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        (clr_poison && !poison_event) |=> !poison_q)
        else $error("Write of one did not clear poison flag.");
    a_poison_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        (poison_q && !clr_poison) |=> poison_q)
        else $error("Poison flag dropped without a clear.");
    a_err_report: assert property (@(posedge aclk) disable iff (!aresetn)
        err_detect.fatal |=> (err_report.fatal == ($past(cmd_q[8]) || $past(dctl_q[1]))))
        else $error("Fatal error reporting does not follow enables.");
    a_irq_gate: assert property (@(posedge aclk) disable iff (!aresetn)
        cmd_q[bcsb_pkg::CMD_IRQ_DIS_BIT] |-> !legacy_irq_assert)
        else $error("Legacy interrupt sent while disabled.");
    a_pend_follow: assert property (@(posedge aclk) disable iff (!aresetn)
        (hotplug_irq && !UPSTREAM_PORT) |=> irq_pend_q)
        else $error("Hot-plug interrupt not shown pending.");
    a_pend_fwd: assert property (@(posedge aclk) disable iff (!aresetn)
        (forwarded_irq && !hotplug_irq) |=> !irq_pend_q)
        else $error("Forwarded interrupt shown as pending.");
    a_pend_up: assert property (@(posedge aclk) disable iff (!aresetn)
        UPSTREAM_PORT |-> !irq_pend_q)
        else $error("Upstream port shows interrupt pending.");
    a_status_read: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_arvalid && s_axi_arready && s_axi_araddr == bcsb_pkg::STS_BYTE_ADDR)
        |=> (rdata_q[4] && rdata_q[15:9] == 7'h00 && rdata_q[7:5] == 3'h0))
        else $error("Status read shows wrong fixed bits.");
    a_cmd_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        (cmd_q & ~bcsb_pkg::CMD_WRITE_MASK) == 16'h0000)
        else $error("Read-only command bit is nonzero.");
    c_poison: cover property (@(posedge aclk) disable iff (!aresetn) poison_event ##[1:20] clr_poison);
    c_irq: cover property (@(posedge aclk) disable iff (!aresetn) legacy_irq_assert);
    c_err: cover property (@(posedge aclk) disable iff (!aresetn) err_report.nonfatal);
    c_clash: cover property (@(posedge aclk) disable iff (!aresetn) poison_event && clr_poison);
    c_masked: cover property (@(posedge aclk) disable iff (!aresetn) irq_pend_q && cmd_q[bcsb_pkg::CMD_IRQ_DIS_BIT]);

    // Flag behaviour at the corners that ordinary traffic seldom reaches.
    a_poison_clash: assert property (@(posedge aclk) disable iff (!aresetn)
        (poison_event && clr_poison) |=> poison_q)
        else $error("Clear won over a poison event in the same cycle.");

    // Checked without a disable, since it is the reset itself that is watched.
    a_poison_reset: assert property (@(posedge aclk)
        !aresetn |=> !poison_q)
        else $error("Poison flag not zero after reset.");

    a_cmd_reset: assert property (@(posedge aclk)
        !aresetn |=> (cmd_q == bcsb_pkg::CMD_RESET))
        else $error("Command word not at reset value after reset.");

    a_pend_drop: assert property (@(posedge aclk) disable iff (!aresetn)
        !hotplug_irq |=> !irq_pend_q)
        else $error("Pending shown without a hot-plug interrupt.");

    // The error report must follow both groups of enables for each severity.
    a_err_nonfatal: assert property (@(posedge aclk) disable iff (!aresetn)
        err_detect.nonfatal |=> (err_report.nonfatal
            == ($past(cmd_q[bcsb_pkg::CMD_ERR_EN_BIT]) || $past(dctl_q[bcsb_pkg::DCTL_NONFATAL_BIT]))))
        else $error("Non-fatal error reporting does not follow enables.");

    a_err_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
        (err_detect == 2'b00) |=> (err_report == 2'b00))
        else $error("Error reported with nothing detected.");

    // Register contents as software sees them.
    a_status_low: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_arvalid && s_axi_arready && s_axi_araddr == bcsb_pkg::STS_BYTE_ADDR)
        |=> (rdata_q[2:0] == 3'h0 && rdata_q[31:16] == 16'h0000))
        else $error("Status read shows nonzero reserved bits.");

    a_status_poison: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_arvalid && s_axi_arready && s_axi_araddr == bcsb_pkg::STS_BYTE_ADDR)
        |=> (rdata_q[bcsb_pkg::STS_POISON_BIT] == $past(poison_q)))
        else $error("Status read does not show the poison flag.");

    a_cmd_read: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_arvalid && s_axi_arready && s_axi_araddr == bcsb_pkg::CMD_BYTE_ADDR)
        |=> (rdata_q == {16'h0000, $past(cmd_q)}))
        else $error("Command read does not show the command word.");

    a_cmd_write: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_fire && awaddr_q == bcsb_pkg::CMD_BYTE_ADDR && wstrb_q == 4'hF)
        |=> (cmd_q == ($past(wdata_q[15:0]) & bcsb_pkg::CMD_WRITE_MASK)))
        else $error("Command write did not land.");

    a_ctl_write: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_fire && awaddr_q == bcsb_pkg::ERRCTL_BYTE_ADDR && wstrb_q[0])
        |=> (dctl_q == $past(wdata_q[1:0])))
        else $error("Device control write did not land.");

    // Bus handshakes: answers come on time and stand until taken.
    a_wr_answer: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready) |=> ##1 s_axi_bvalid)
        else $error("Write response late.");

    a_rd_answer: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
        else $error("Read response late.");

    a_bvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_bvalid && !s_axi_bready) |=> (s_axi_bvalid && $stable(s_axi_bresp)))
        else $error("Write response dropped before taken.");

    a_rvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_rvalid && !s_axi_rready) |=> (s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp)))
        else $error("Read response dropped before taken.");

    a_unmapped_rd: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_arvalid && s_axi_arready && !mapped(s_axi_araddr))
        |=> (rresp_q == bcsb_pkg::RESP_SLVERR && rdata_q == 32'h00000000))
        else $error("Unmapped read not answered with an error.");

    a_unmapped_wr: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_fire && !mapped(awaddr_q)) |=> (bresp_q == bcsb_pkg::RESP_SLVERR))
        else $error("Unmapped write not answered with an error.");

    // A write that is not to the status word must leave the poison flag alone.
    a_poison_keep: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_fire && awaddr_q != bcsb_pkg::STS_BYTE_ADDR && poison_q) |=> poison_q)
        else $error("Poison flag cleared by a write elsewhere.");

endmodule : bcsb_regs
`default_nettype wire

//--- verification/bcsb_cfg_model.sv
`timescale 1ns/1ps
`default_nettype none
module bcsb_cfg_model (
    input wire logic aclk, // Bus clock.
    output logic [11:0] awaddr, // Write address.
    output logic awvalid, // Write address valid.
    input wire logic awready, // Write address ready.
    output logic [31:0] wdata, // Write data.
    output logic [3:0] wstrb, // Write strobes.
    output logic wvalid, // Write data valid.
    input wire logic wready, // Write data ready.
    input wire logic [1:0] bresp, // Write response.
    input wire logic bvalid, // Write response valid.
    output logic bready, // Write response ready.
    output logic [11:0] araddr, // Read address.
    output logic arvalid, // Read address valid.
    input wire logic arready, // Read address ready.
    input wire logic [31:0] rdata, // Read data.
    input wire logic [1:0] rresp, // Read response.
    input wire logic rvalid, // Read data valid.
    output logic rready // Read data ready.
);
    initial {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;

    // Handshakes are sampled at the falling edge, which shows what the slave presents at the next rising edge.
    task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ta;
        logic tw;
        logic tb;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        tb = 1'b0;
        while (!tb)
        begin
            @(negedge aclk);
            ta = awvalid & awready;
            tw = wvalid & wready;
            tb = bvalid;
            r = bresp;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tb) bready <= 1'b0;
        end
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ta;
        logic tr;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        tr = 1'b0;
        while (!tr)
        begin
            @(negedge aclk);
            ta = arvalid & arready;
            tr = rvalid;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
            if (tr) rready <= 1'b0;
        end
    endtask : rd
endmodule : bcsb_cfg_model
`default_nettype wire

//--- verification/bridge_command_status_bits_test.sv
`timescale 1ns/1ps
`default_nettype none
module bridge_command_status_bits_test;
    typedef struct {logic [11:0] a; logic [31:0] w; logic [31:0] e; logic [1:0] resp;} bcsb_row_s;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    bcsb_pkg::bcsb_traffic_s traffic = '0;
    bcsb_pkg::bcsb_err_s err_detect = '0, err_report;
    logic hotplug_irq = 1'b0, forwarded_irq = 1'b0, irq, up_irq, pe, ee;
    int num_errors = 0, samples_checked = 0;
    localparam logic [11:0] CMD = bcsb_pkg::CMD_BYTE_ADDR;
    localparam logic [11:0] STS = bcsb_pkg::STS_BYTE_ADDR;
    localparam logic [11:0] ECTL = bcsb_pkg::ERRCTL_BYTE_ADDR;
    bcsb_row_s rows [6] = '{'{CMD, 32'hFFFFFFFF, 32'h00000540, 2'h0}, '{STS, 32'hFFFFFFFF, 32'h00000010, 2'h0},
        '{ECTL, 32'h00000003, 32'h00000003, 2'h0}, '{ECTL, 32'h0, 32'h0, 2'h0},
        '{CMD, 32'h0, 32'h0, 2'h0}, '{12'h030, 32'hFFFFFFFF, 32'h0, 2'h2}};

    always #50 aclk = ~aclk;

    bcsb_cfg_model bcsb_cfg_model_i (.aclk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
        .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
    bcsb_regs bcsb_regs_i (.aclk, .aresetn, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .traffic, .err_detect, .hotplug_irq, .forwarded_irq, .legacy_irq_assert(irq),
        .err_report, .poison_report_enable(pe), .error_report_enable(ee));
    // The upstream copy sees the same traffic; only its interrupt output is judged.
    bcsb_regs #(.UPSTREAM_PORT(1'b1)) bcsb_regs_up_i (.aclk, .aresetn, .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(), .s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid(),
        .s_axi_rready(rready), .traffic, .err_detect, .hotplug_irq, .forwarded_irq, .legacy_irq_assert(up_irq),
        .err_report(), .poison_report_enable(), .error_report_enable());

    task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e)
        begin
            $display("BAD %s expected %h seen %h", n, e, s);
            num_errors++;
        end
    endtask : check

    task automatic wr(input logic [11:0] a, input logic [31:0] w);
        bcsb_cfg_model_i.wr(a, w, r);
    endtask : wr

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
        bcsb_cfg_model_i.rd(a, d, r);
        check("rdata", d, e);
        check("rresp", {30'h0, r}, {30'h0, er});
    endtask : rd_chk

    task automatic pulse(input logic [2:0] t, input logic [1:0] er);
        @(posedge aclk);
        traffic <= t;
        err_detect <= er;
        @(posedge aclk);
        traffic <= 3'h0;
        err_detect <= 2'h0;
        @(negedge aclk);
    endtask : pulse

    task automatic print_verdict();
        if (num_errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : print_verdict

    initial
    begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rd_chk(STS, 32'h10, 2'h0);
        rd_chk(bcsb_pkg::PORT_BYTE_ADDR, 32'h0, 2'h0);
        foreach (rows[i])
        begin
            wr(rows[i].a, rows[i].w);
            check("bresp", {30'h0, r}, {30'h0, rows[i].resp});
            rd_chk(rows[i].a, rows[i].e, rows[i].resp);
        end
        wr(CMD, 32'h40);
        check("poison_en", {31'h0, pe}, 32'h1);
        pulse(3'b101, 2'h0);
        rd_chk(STS, 32'h110, 2'h0);
        wr(STS, 32'h0);
        rd_chk(STS, 32'h110, 2'h0);
        wr(STS, 32'h100);
        rd_chk(STS, 32'h10, 2'h0);
        pulse(3'b011, 2'h0);
        rd_chk(STS, 32'h110, 2'h0);
        wr(STS, 32'h100);
        pulse(3'b110, 2'h0);
        rd_chk(STS, 32'h10, 2'h0);
        wr(CMD, 32'h0);
        pulse(3'b111, 2'h0);
        rd_chk(STS, 32'h10, 2'h0);
        pulse(3'h0, 2'b11);
        check("err_off", {30'h0, err_report}, 32'h0);
        wr(CMD, 32'h100);
        pulse(3'h0, 2'b11);
        check("err_cmd", {30'h0, err_report}, 32'h3);
        check("err_en", {31'h0, ee}, 32'h1);
        wr(CMD, 32'h0);
        wr(ECTL, 32'h3);
        pulse(3'h0, 2'b01);
        check("err_dctl", {30'h0, err_report}, 32'h1);
        wr(ECTL, 32'h0);
        @(posedge aclk);
        hotplug_irq <= 1'b1;
        repeat (2) @(negedge aclk);
        check("irq", {31'h0, irq}, 32'h1);
        check("up_irq", {31'h0, up_irq}, 32'h0);
        rd_chk(STS, 32'h18, 2'h0);
        wr(CMD, 32'h400);
        check("irq_dis", {31'h0, irq}, 32'h0);
        @(posedge aclk);
        hotplug_irq <= 1'b0;
        forwarded_irq <= 1'b1;
        wr(CMD, 32'h0);
        rd_chk(STS, 32'h10, 2'h0);
        check("irq_fwd", {31'h0, irq}, 32'h0);
        // The event is seen only at the edge where the clearing write lands, so only a set that wins shows.
        wr(CMD, 32'h40);
        fork
            wr(STS, 32'h100);
            begin
                repeat (2) @(posedge aclk);
                traffic <= 3'b101;
                @(posedge aclk);
                traffic <= 3'h0;
            end
        join
        rd_chk(STS, 32'h110, 2'h0);
        wr(STS, 32'h100);
        rd_chk(STS, 32'h10, 2'h0);
        // A reset in mid-run must bring back the reset values.
        wr(CMD, 32'h540);
        pulse(3'b101, 2'h0);
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        check("pe_rst", {31'h0, pe}, 32'h0);
        rd_chk(CMD, 32'h0, 2'h0);
        rd_chk(STS, 32'h10, 2'h0);
        print_verdict();
    end

    initial
    begin
        repeat (3000) @(posedge aclk);
        num_errors++;
        print_verdict();
    end
endmodule : bridge_command_status_bits_test
`default_nettype wire
